// File: hw/ssc_params.svh
// Constants of the step sequencer: register map, field positions, mode codes, levels.
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// APB register byte offsets.
`define SSC_REG_CTRL 8'h00
`define SSC_REG_STATUS 8'h04

// Control register fields.
`define SSC_CTRL_DIR_BIT 0
`define SSC_CTRL_RESET 32'h0000_0000

// Status register field positions.
`define SSC_ST_POS_LSB 0
`define SSC_ST_MODE_LSB 8
`define SSC_ST_EN_BIT 12
`define SSC_ST_RUN_BIT 13
`define SSC_ST_INIT_BIT 14

// Step resolution codes as {sel_a, sel_b, sel_c}.
`define SSC_MODE_FULL 3'h1
`define SSC_MODE_HALF_A 3'h2
`define SSC_MODE_HALF_B 3'h3
`define SSC_MODE_QUARTER 3'h4
`define SSC_MODE_EIGHTH 3'h5
`define SSC_MODE_SIXTEENTH 3'h6

// Position increments in sixteenth-step units.
`define SSC_INC_FULL 6'h10
`define SSC_INC_HALF 6'h08
`define SSC_INC_QUARTER 6'h04
`define SSC_INC_EIGHTH 6'h02
`define SSC_INC_SIXTEENTH 6'h01
`define SSC_INC_NONE 6'h00

// Initial position and quarter-cycle offset; full-current level index.
`define SSC_POS_INIT 6'h00
`define SSC_POS_QUARTER 6'h10
`define SSC_LVL_FULL 5'h10

`endif

// File: hw/ssc_pkg.sv
// Types shared by the step sequencer modules.
`default_nettype none
package ssc_pkg;
  // Electrical position, 64 sixteenth steps per cycle.
  typedef logic [5:0] ssc_pos_t;
  // Phase drive: sign in bit 5, level index 0..16 below it.
  typedef logic [5:0] ssc_lvl_t;
  // Step resolution select code.
  typedef logic [2:0] ssc_mode_t;
endpackage
`default_nettype wire

// File: hw/ssc_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
`default_nettype none
module ssc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Levels.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // ssc_sync
`default_nettype wire

// File: hw/ssc_top.sv
// Step sequencer control of a bipolar micro-step driver, with an APB control and status port.
//
// Notes on behaviour
// RULE1: Controller keeps enable low while motor supply is applied or removed.
// RULE2: Each rising step clock edge advances the position by one step.
// RULE3: Enable low floats motor outputs; enable high drives them.
// RULE4: Reset pin low holds position at start: phase A full, B zero.
// RULE5: Enable and reset both low: outputs float, position held at start.
// RULE6: Enable low, reset high: outputs float, counter still follows steps.
// RULE7: Enable high, reset low: drive start levels whatever the clock does.
// RULE8: Enable and reset high: drive levels chosen by the present position.
// RULE9: Controller should raise enable first and release reset afterwards.
// RULE10: A change of resolution select restarts from the start position.
// RULE11: Initial flag pulls low at the start position, floats otherwise.
// RULE12: Counter wraps after one electrical cycle of the selected resolution.
//
// The implementer's own choices: the address map and the APB slave port.
`include "ssc_params.svh"
`default_nettype none
module ssc_top (
  // System clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Controller pins, asynchronous to CLK.
  input wire logic STEP_CLK,
  input wire logic ENABLE,
  input wire logic STEP_RESET_N,
  input wire logic STEP_RES_SEL_A,
  input wire logic STEP_RES_SEL_B,
  input wire logic STEP_RES_SEL_C,
  // Phase drive to the power stage.
  output logic [4:0] PHASE_A_LEVEL,
  output logic PHASE_A_NEG,
  output logic [4:0] PHASE_B_LEVEL,
  output logic PHASE_B_NEG,
  output logic MOTOR_OE_N,
  // Open-drain initial-position flag.
  output logic INIT_STATE_FLAG_OUT,
  output logic INIT_STATE_FLAG_OE_N,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Step increment for a resolution code; unknown codes do not move.
  function automatic ssc_pkg::ssc_pos_t step_inc(input ssc_pkg::ssc_mode_t m);
    case (m)
      `SSC_MODE_FULL: step_inc = `SSC_INC_FULL;
      `SSC_MODE_HALF_A, `SSC_MODE_HALF_B: step_inc = `SSC_INC_HALF;
      `SSC_MODE_QUARTER: step_inc = `SSC_INC_QUARTER;
      `SSC_MODE_EIGHTH: step_inc = `SSC_INC_EIGHTH;
      `SSC_MODE_SIXTEENTH: step_inc = `SSC_INC_SIXTEENTH;
      default: step_inc = `SSC_INC_NONE;
    endcase
  endfunction

  // Phase A drive for a position; phase B is the same a quarter cycle later.
  function automatic ssc_pkg::ssc_lvl_t phase_lvl(input ssc_pkg::ssc_pos_t p);
    logic [4:0] k;
    logic [4:0] rest;
    k = {1'b0, p[3:0]};
    rest = `SSC_LVL_FULL - k;
    case (p[5:4])
      2'h0: phase_lvl = {1'b0, rest};
      2'h1: phase_lvl = {1'b1, k};
      2'h2: phase_lvl = {1'b1, rest};
      default: phase_lvl = {1'b0, k};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  logic rst_meta_r;
  logic rst_n_s;

  // Reset asserts at once and releases after two edges.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_r <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_s <= rst_meta_r;
    end
  end

  logic [5:0] pins_s;
  logic stp_s;
  logic en_s;
  logic run_s;
  ssc_pkg::ssc_mode_t mode_s;

  ssc_sync #(.W(6)) u_sync (
    .clk(CLK),
    .rst_n(rst_n_s),
    .d({STEP_CLK, ENABLE, STEP_RESET_N, STEP_RES_SEL_A, STEP_RES_SEL_B, STEP_RES_SEL_C}),
    .q(pins_s)
  );

  // Synchronised pin levels.
  assign stp_s = pins_s[5];
  assign en_s = pins_s[4];
  assign run_s = pins_s[3];
  assign mode_s = pins_s[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Step position counter.

  logic stp_d_r;
  ssc_pkg::ssc_mode_t mode_prev_r;
  ssc_pkg::ssc_pos_t pos_r;
  ssc_pkg::ssc_pos_t inc;
  logic dir_ccw_r;
  logic step_rise;
  logic mode_chg;

  assign step_rise = stp_s & ~stp_d_r;
  assign mode_chg = mode_s != mode_prev_r;
  assign inc = step_inc(mode_s);

  // Edge and change detection look only at synchronised levels.
  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      stp_d_r <= 1'b0;
      mode_prev_r <= '0;
    end else begin
      stp_d_r <= stp_s;
      mode_prev_r <= mode_s;
    end
  end

  // Counter runs regardless of enable, so floating outputs do not lose steps.
  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pos_r <= `SSC_POS_INIT;
    end else if (!run_s) begin
      pos_r <= `SSC_POS_INIT; // RULE4 RULE5
    end else if (mode_chg) begin
      pos_r <= `SSC_POS_INIT; // RULE10
    end else if (step_rise) begin
      // Six-bit arithmetic wraps naturally at one electrical cycle.
      pos_r <= dir_ccw_r ? pos_r - inc : pos_r + inc; // RULE2 RULE6 RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase drive outputs.

  ssc_pkg::ssc_lvl_t lvl_a;
  ssc_pkg::ssc_lvl_t lvl_b;

  assign lvl_a = phase_lvl(pos_r);
  assign lvl_b = phase_lvl(pos_r - `SSC_POS_QUARTER);

  // Levels follow the position one cycle later; enable gates drive only.
  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      PHASE_A_LEVEL <= `SSC_LVL_FULL;
      PHASE_A_NEG <= 1'b0;
      PHASE_B_LEVEL <= '0;
      PHASE_B_NEG <= 1'b0;
      MOTOR_OE_N <= 1'b1;
    end else begin
      PHASE_A_LEVEL <= lvl_a[4:0]; // RULE7 RULE8
      PHASE_A_NEG <= lvl_a[5];
      PHASE_B_LEVEL <= lvl_b[4:0];
      PHASE_B_NEG <= lvl_b[5];
      MOTOR_OE_N <= ~en_s; // RULE3
    end
  end

  // Open-drain flag: pull low only at the start position.
  assign INIT_STATE_FLAG_OUT = 1'b0;
  assign INIT_STATE_FLAG_OE_N = pos_r != `SSC_POS_INIT; // RULE11

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped addresses.

  logic hit_ctrl;
  logic hit_status;
  logic [31:0] status_w;

  assign hit_ctrl = PADDR == `SSC_REG_CTRL;
  assign hit_status = PADDR == `SSC_REG_STATUS;
  assign PREADY = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & ~(hit_ctrl | hit_status);

  always_comb begin
    status_w = '0;
    status_w[`SSC_ST_POS_LSB +: 6] = pos_r;
    status_w[`SSC_ST_MODE_LSB +: 3] = mode_s;
    status_w[`SSC_ST_EN_BIT] = en_s;
    status_w[`SSC_ST_RUN_BIT] = run_s;
    status_w[`SSC_ST_INIT_BIT] = pos_r == `SSC_POS_INIT;
  end

  // Writes take effect at the access edge; a direction change acts on the next step.
  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      // A literal cannot be bit-selected, so the field is shifted down and cut to one bit.
      dir_ccw_r <= 1'(`SSC_CTRL_RESET >> `SSC_CTRL_DIR_BIT);
    end else if (PSEL && PENABLE && PWRITE && hit_ctrl) begin
      dir_ccw_r <= PWDATA[`SSC_CTRL_DIR_BIT];
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= hit_ctrl ? {31'h0, dir_ccw_r} : (hit_status ? status_w : 32'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_s);

  ssc_pkg::ssc_pos_t pos_fwd;
  assign pos_fwd = pos_r + inc;

  a_step_advance: assert property ( // RULE2
    run_s && !mode_chg && step_rise && !dir_ccw_r |=> pos_r == $past(pos_fwd))
    else $error("position did not advance on a step edge");
  a_output_float: assert property ( // RULE3
    1'b1 |=> MOTOR_OE_N == !$past(en_s))
    else $error("output enable does not follow enable");
  a_reset_hold: assert property ( // RULE4
    !run_s ##1 !run_s |-> pos_r == `SSC_POS_INIT && lvl_a == {1'b0, `SSC_LVL_FULL})
    else $error("reset does not hold the start position");
  a_off_idle: assert property ( // RULE5
    !en_s && !run_s |=> MOTOR_OE_N && pos_r == `SSC_POS_INIT)
    else $error("disabled reset state not floating at start");
  a_float_count: assert property ( // RULE6
    !en_s && run_s && !mode_chg && step_rise && inc != '0 |=>
      MOTOR_OE_N && pos_r != $past(pos_r))
    else $error("counter stopped while outputs float");
  a_drive_start: assert property ( // RULE7
    (en_s && !run_s)[*2] |=>
      !MOTOR_OE_N && PHASE_A_LEVEL == `SSC_LVL_FULL && PHASE_B_LEVEL == 5'h00)
    else $error("start levels not driven under reset");
  a_drive_pos: assert property ( // RULE8
    en_s && run_s |=> {PHASE_B_NEG, PHASE_B_LEVEL} ==
      phase_lvl($past(pos_r) - `SSC_POS_QUARTER))
    else $error("phase B level does not match position");
  a_mode_restart: assert property ( // RULE10
    run_s && mode_chg |=> pos_r == `SSC_POS_INIT && !INIT_STATE_FLAG_OE_N)
    else $error("resolution change did not restart");
  a_flag_start: assert property ( // RULE11
    !run_s |=> !INIT_STATE_FLAG_OE_N && INIT_STATE_FLAG_OUT == 1'b0)
    else $error("initial flag not pulled at start");
  a_cycle_wrap: assert property ( // RULE12
    run_s && !mode_chg && step_rise && !dir_ccw_r && inc != '0 &&
      pos_r == 6'h00 - inc |=> pos_r == `SSC_POS_INIT)
    else $error("counter did not wrap after one cycle");

endmodule // ssc_top
`default_nettype wire

// File: testbench/ssc_ctrl_model.sv
// Motion controller model that drives the step sequencer pins.
`include "ssc_params.svh"
`default_nettype none
module ssc_ctrl_model (
  // Clock used only to time pin changes.
  input wire logic clk,
  // Controller pins.
  output logic step_clk,
  output logic enable,
  output logic step_reset_n,
  output logic [2:0] sel
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  // Supply ramps with the outputs disabled and the device held at start.
  initial begin
    step_clk = 1'b0;
    enable = 1'b0;
    step_reset_n = 1'b0;
    sel = `SSC_MODE_FULL;
  end
  // Set enable and reset levels, then let the pin synchronisers settle.
  task pins(input logic en, input logic rn);
    @(posedge clk);
    enable <= en;
    step_reset_n <= rn;
    repeat (6) @(posedge clk);
  endtask
  // Enable goes up first so the motor starts driven from the start position.
  task start();
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b1);
  endtask
  // Pulses are three clocks high and at least four low, wider than the two-flop capture needs.
  task steps(input int n);
    repeat (n) begin
      @(posedge clk);
      step_clk <= 1'b1;
      repeat (3) @(posedge clk);
      step_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  // Change the resolution select code.
  task mode(input logic [2:0] m);
    @(posedge clk);
    sel <= m;
    repeat (6) @(posedge clk);
  endtask
endmodule // ssc_ctrl_model
`default_nettype wire

// File: testbench/tb.sv
// Self-checking testbench of the step sequencer.
`include "ssc_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic sclk, en, srn, a_neg, b_neg, oe_n, fl_out, fl_oe_n, flag;
  logic [2:0] sel;
  logic [4:0] a_lvl, b_lvl;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int errors, compares;
  ////////////////////////////////////////////////////////////////////////////////
  ssc_ctrl_model ctl_u (.clk(clk), .step_clk(sclk), .enable(en), .step_reset_n(srn), .sel(sel));
  ssc_top dut_u (.CLK(clk), .RST_N(rst_n), .STEP_CLK(sclk), .ENABLE(en), .STEP_RESET_N(srn),
    .STEP_RES_SEL_A(sel[2]), .STEP_RES_SEL_B(sel[1]), .STEP_RES_SEL_C(sel[0]),
    .PHASE_A_LEVEL(a_lvl), .PHASE_A_NEG(a_neg), .PHASE_B_LEVEL(b_lvl), .PHASE_B_NEG(b_neg),
    .MOTOR_OE_N(oe_n), .INIT_STATE_FLAG_OUT(fl_out), .INIT_STATE_FLAG_OE_N(fl_oe_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  // The flag line has a pull-up, so it reads high whenever the pin floats.
  assign flag = fl_oe_n ? 1'b1 : fl_out;
  // Clock of 25 ns.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Print the verdict and stop.
  task results();
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Compare one value.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the wait for pready is bounded so a dead slave ends the run.
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 10) begin
      n++;
      @(posedge clk);
    end
    if (pready !== 1'b1) begin
      errors++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Read the position field of the status word.
  task pos_is(input logic [5:0] exp);
    apb(1'b0, `SSC_REG_STATUS, 32'h0);
    chk({26'h0, rd[5:0]}, {26'h0, exp});
  endtask
  // Drive levels and enable as one word.
  task outs_are(input logic [4:0] a, input logic [4:0] b, input logic oen);
    chk({a_lvl, b_lvl, oe_n}, {a, b, oen});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Both pins low: floating outputs, steps ignored, start levels and flag low.
  task t_idle();
    ctl_u.steps(2);
    outs_are(5'h10, 5'h00, 1'b1);
    chk(flag, 1'b0);
    pos_is(6'h00);
  endtask
  // Disabled but counting: one full step moves the counter while outputs float.
  task t_count_hiz();
    ctl_u.pins(1'b0, 1'b1);
    ctl_u.steps(1);
    pos_is(6'h10);
    outs_are(5'h00, 5'h10, 1'b1);
    chk(flag, 1'b1);
  endtask
  // Enabled under reset: start levels driven whatever the clock does.
  task t_reset_drive();
    ctl_u.pins(1'b1, 1'b0);
    ctl_u.steps(3);
    outs_are(5'h10, 5'h00, 1'b0);
    pos_is(6'h00);
  endtask
  // Running: half a cycle flips phase A, a full cycle wraps to start.
  task t_run();
    ctl_u.pins(1'b0, 1'b0);
    ctl_u.start();
    ctl_u.steps(2);
    chk({a_lvl, a_neg, b_lvl, oe_n}, {5'h10, 1'b1, 5'h00, 1'b0});
    ctl_u.steps(2);
    pos_is(6'h00);
    chk(flag, 1'b0);
  endtask
  // Every resolution code: restart on change, last position, then wrap.
  task t_modes();
    logic [2:0] codes [6];
    int incs [6];
    codes = '{`SSC_MODE_HALF_A, `SSC_MODE_HALF_B, `SSC_MODE_QUARTER, `SSC_MODE_EIGHTH,
      `SSC_MODE_SIXTEENTH, `SSC_MODE_FULL};
    incs = '{8, 8, 4, 2, 1, 16};
    for (int i = 0; i < 6; i++) begin
      // Leave the start position first so that the restart is visible.
      ctl_u.steps(1);
      ctl_u.mode(codes[i]);
      pos_is(6'h00);
      ctl_u.steps(64 / incs[i] - 1);
      pos_is(6'(64 - incs[i]));
      ctl_u.steps(1);
      pos_is(6'h00);
    end
    // Codes 000 and 111 select no resolution, so steps must not move the position.
    ctl_u.mode(3'h0);
    ctl_u.steps(2);
    pos_is(6'h00);
    ctl_u.mode(3'h7);
    ctl_u.steps(2);
    pos_is(6'h00);
    ctl_u.mode(`SSC_MODE_FULL);
  endtask
  // Registers: reset value, reverse stepping, status flags, unmapped address.
  task t_regs();
    apb(1'b0, `SSC_REG_CTRL, 32'h0);
    chk(rd, `SSC_CTRL_RESET);
    apb(1'b1, `SSC_REG_CTRL, 32'hffff_ffff);
    apb(1'b0, `SSC_REG_CTRL, 32'h0);
    chk(rd, 32'h0000_0001);
    ctl_u.steps(1);
    pos_is(6'h30);
    chk({27'h0, rd[14:12], b_neg, a_lvl == 5'h00}, {27'h0, 3'b011, 2'b11});
    apb(1'b1, 8'h08, 32'h0000_0001);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  // System reset in mid-run: start levels, cleared read data and direction, restart.
  task t_sys_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    outs_are(5'h10, 5'h00, 1'b1);
    chk(prdata, 32'h0);
    chk(flag, 1'b0);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, `SSC_REG_CTRL, 32'h0);
    chk(rd, `SSC_CTRL_RESET);
    pos_is(6'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset for five clocks, then the scenarios in order.
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_idle();
    t_count_hiz();
    t_reset_drive();
    t_run();
    t_modes();
    t_regs();
    t_sys_reset();
    results();
  end
endmodule // tb
`default_nettype wire
